// *** design/gpio_ctrl_defs.svh ***
// register map, field layout, reset values and bus codes of the io line
// controller; included by the controller, needs no other file
// Notes on behaviour
// - thirty-two lines, one bit position per line
// - pull-up enable clears, disable sets status
// - pull-up works always; resets to all enabled
// - ownership enable sets, disable clears status bit
// - unmuxed line: ownership fixed at one
// - ownership reset value is a build parameter
// - a-select clears, b-select sets selection bit
// - selection steers outputs; inputs see pin
// - selection resets to peripheral a
// - selection writes work whatever the ownership
// - peripheral owned line: peripheral drives pin
// - output enable sets, disable clears direction
// - set and clear writes move output data
// - direction and data writes work while peripheral-owned
// - direct data write touches only unmasked bits
// - write mask resets to all zero
// - multi-drive line drives low only
// - multi-drive resets to all disabled
// - writes need no clock; pin reads do
// - pin level register shows the real pin
// - absent lines ignore writes, read zero
`ifndef GPIO_CTRL_DEFS_SVH
`define GPIO_CTRL_DEFS_SVH

`define ADDR_W 8
`define LINES 32

`define OFF_OWN_EN 8'h00
`define OFF_OWN_DIS 8'h04
`define OFF_OWN_STAT 8'h08
`define OFF_OUT_EN 8'h10
`define OFF_OUT_DIS 8'h14
`define OFF_OUT_STAT 8'h18
`define OFF_SET_OUT 8'h30
`define OFF_CLR_OUT 8'h34
`define OFF_ODATA_STAT 8'h38
`define OFF_PIN_LEVEL 8'h3C
`define OFF_MD_EN 8'h50
`define OFF_MD_DIS 8'h54
`define OFF_MD_STAT 8'h58
`define OFF_PU_DIS 8'h60
`define OFF_PU_EN 8'h64
`define OFF_PU_STAT 8'h68
`define OFF_SEL_A 8'h70
`define OFF_SEL_B 8'h74
`define OFF_SEL_STAT 8'h78
`define OFF_WM_EN 8'hA0
`define OFF_WM_DIS 8'hA4
`define OFF_WM_STAT 8'hA8
`define OFF_CLK_CTRL 8'hC0

`define CLK_CTRL_ON_BIT 0
`define RST_ZERO 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** design/gpio_ctrl_pkg.sv ***
// types shared by the io line controller
// assumes the constants header for the line count and address width
`default_nettype none
`include "gpio_ctrl_defs.svh"
package gpio_ctrl_pkg;
	typedef logic [`LINES-1:0] lines_type;

	typedef struct packed {
		lines_type ownership_status;
		lines_type ab_status;
		lines_type output_status;
		lines_type odata_status;
		lines_type wmask_status;
		lines_type md_status;
		lines_type pu_status;
		lines_type pin_level;
		logic clk_on;
		lines_type sync_a;
		lines_type sync_b;
		lines_type pad_out;
		lines_type pad_oe;
		lines_type pull_on;
		lines_type periph_in;
		logic awready;
		logic aw_held;
		logic [`ADDR_W-1:0] aw_addr;
		logic wready;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_type;
endpackage : gpio_ctrl_pkg
`default_nettype wire

// *** design/io_drive_select.sv ***
// per-line choice of who drives each pad and how
// purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module io_drive_select #(
	parameter int W = 32
) (
	// configuration
	input wire logic [W-1:0] own,
	input wire logic [W-1:0] sel_b,
	input wire logic [W-1:0] out_en,
	input wire logic [W-1:0] out_data,
	input wire logic [W-1:0] multi,
	// peripheral drive requests
	input wire logic [W-1:0] a_out,
	input wire logic [W-1:0] a_oe,
	input wire logic [W-1:0] b_out,
	input wire logic [W-1:0] b_oe,
	// pad drive
	output logic [W-1:0] drv_out,
	output logic [W-1:0] drv_oe
);
	logic [W-1:0] level;
	logic [W-1:0] enable;

	if (W < 1) begin : g_bad_width
		$error("drive select needs at least one line");
	end

	always_comb begin
		// owned lines use controller state, others the selected peripheral
		level = (own & out_data) | (~own & ((sel_b & b_out) | (~sel_b & a_out)));
		enable = (own & out_en) | (~own & ((sel_b & b_oe) | (~sel_b & a_oe)));
		// multi-drive: a high level releases the pad instead of driving it
		drv_oe = enable & ~(multi & level);
		drv_out = level & ~multi;
	end
endmodule : io_drive_select
`default_nettype wire

// *** design/parallel_io_controller.sv ***
// thirty-two line io controller with axi4-lite register slave
// assumes pin_in is asynchronous and peripheral lines share aclk
`timescale 1ns/1ps
`default_nettype none
`include "gpio_ctrl_defs.svh"
module parallel_io_controller #(
	parameter gpio_ctrl_pkg::lines_type LINE_PRESENT = 32'hFFFF_FFFF,
	parameter gpio_ctrl_pkg::lines_type MUX_PRESENT = 32'hFFFF_FFFF,
	parameter gpio_ctrl_pkg::lines_type OWNERSHIP_RESET = 32'hFFFF_FFFF
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [`ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// read
	input wire logic arvalid,
	output logic arready,
	input wire logic [`ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// pads
	input wire gpio_ctrl_pkg::lines_type pin_in,
	output gpio_ctrl_pkg::lines_type pin_out,
	output gpio_ctrl_pkg::lines_type pin_oe,
	output gpio_ctrl_pkg::lines_type pin_pullup_en,
	// on-chip peripherals
	input wire gpio_ctrl_pkg::lines_type periph_a_out,
	input wire gpio_ctrl_pkg::lines_type periph_a_oe,
	input wire gpio_ctrl_pkg::lines_type periph_b_out,
	input wire gpio_ctrl_pkg::lines_type periph_b_oe,
	output gpio_ctrl_pkg::lines_type periph_in
);
	import gpio_ctrl_pkg::*;

	// lines with no peripheral behind them are always controller-owned
	localparam lines_type FIXED_OWN = LINE_PRESENT & ~MUX_PRESENT;

	if ((MUX_PRESENT & ~LINE_PRESENT) != `RST_ZERO) begin : g_bad_mux
		$error("peripheral mux declared on an absent line");
	end
	if ((FIXED_OWN & ~OWNERSHIP_RESET) != `RST_ZERO) begin : g_bad_own
		$error("unmuxed line cannot reset to peripheral ownership");
	end

	localparam state_type RESET_STATE = '{
		ownership_status: OWNERSHIP_RESET & LINE_PRESENT,
		pull_on: LINE_PRESENT,
		awready: 1'b1,
		wready: 1'b1,
		arready: 1'b1,
		default: '0
	};

	state_type st_reg;
	state_type st_next;
	lines_type drv_out;
	lines_type drv_oe;
	lines_type byte_mask;
	lines_type act_bits;
	lines_type own_mask;
	logic wr_do;
	logic [`ADDR_W-1:0] wr_addr;

	io_drive_select #(
		.W(`LINES)
	) u_drive (
		.own(st_reg.ownership_status),
		.sel_b(st_reg.ab_status),
		.out_en(st_reg.output_status),
		.out_data(st_reg.odata_status),
		.multi(st_reg.md_status),
		.a_out(periph_a_out),
		.a_oe(periph_a_oe),
		.b_out(periph_b_out),
		.b_oe(periph_b_oe),
		.drv_out(drv_out),
		.drv_oe(drv_oe)
	);

	always_comb begin
		st_next = st_reg;
		wr_do = 1'b0;
		wr_addr = st_reg.aw_addr;
		byte_mask = '0;
		act_bits = '0;
		own_mask = '0;

		// first stage feeds only the second
		st_next.sync_a = pin_in;
		st_next.sync_b = st_reg.sync_a;
		// with the clock stopped the last sampled levels stay visible
		if (st_reg.clk_on) begin
			st_next.pin_level = st_reg.sync_b & LINE_PRESENT;
		end
		st_next.periph_in = st_reg.sync_b & LINE_PRESENT;

		st_next.pad_out = drv_out & LINE_PRESENT;
		st_next.pad_oe = drv_oe & LINE_PRESENT;
		st_next.pull_on = ~st_reg.pu_status & LINE_PRESENT;

		// write channel: address and data taken in either order
		if (awvalid && st_reg.awready) begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = awaddr;
		end
		if (wvalid && st_reg.wready) begin
			st_next.w_held = 1'b1;
			st_next.w_data = wdata;
			st_next.w_strb = wstrb;
		end
		if (st_reg.bvalid && bready) begin
			st_next.bvalid = 1'b0;
		end
		// every write lands on an aclk edge; no gated clock is involved
		if (st_next.aw_held && st_next.w_held && !st_next.bvalid) begin
			wr_do = 1'b1;
			wr_addr = st_next.aw_addr;
			byte_mask = {{8{st_next.w_strb[3]}}, {8{st_next.w_strb[2]}},
				{8{st_next.w_strb[1]}}, {8{st_next.w_strb[0]}}};
			// in enable, disable, select, set and clear writes only ones in enabled bytes of present lines do anything
			act_bits = st_next.w_data & byte_mask & LINE_PRESENT;
			own_mask = byte_mask & st_reg.wmask_status & LINE_PRESENT;
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `RESP_OKAY;
			case (wr_addr)
				`OFF_OWN_EN: begin
					st_next.ownership_status = st_reg.ownership_status | act_bits;
				end
				`OFF_OWN_DIS: begin
					st_next.ownership_status = st_reg.ownership_status & ~act_bits;
				end
				`OFF_OUT_EN: begin
					st_next.output_status = st_reg.output_status | act_bits;
				end
				`OFF_OUT_DIS: begin
					st_next.output_status = st_reg.output_status & ~act_bits;
				end
				`OFF_SET_OUT: begin
					st_next.odata_status = st_reg.odata_status | act_bits;
				end
				`OFF_CLR_OUT: begin
					st_next.odata_status = st_reg.odata_status & ~act_bits;
				end
				`OFF_ODATA_STAT: begin
					st_next.odata_status = (st_reg.odata_status & ~own_mask)
						| (st_next.w_data & own_mask);
				end
				`OFF_MD_EN: begin
					st_next.md_status = st_reg.md_status | act_bits;
				end
				`OFF_MD_DIS: begin
					st_next.md_status = st_reg.md_status & ~act_bits;
				end
				`OFF_PU_DIS: begin
					st_next.pu_status = st_reg.pu_status | act_bits;
				end
				`OFF_PU_EN: begin
					st_next.pu_status = st_reg.pu_status & ~act_bits;
				end
				`OFF_SEL_A: begin
					st_next.ab_status = st_reg.ab_status & ~act_bits;
				end
				`OFF_SEL_B: begin
					st_next.ab_status = st_reg.ab_status | act_bits;
				end
				`OFF_WM_EN: begin
					st_next.wmask_status = st_reg.wmask_status | act_bits;
				end
				`OFF_WM_DIS: begin
					st_next.wmask_status = st_reg.wmask_status & ~act_bits;
				end
				`OFF_CLK_CTRL: begin
					if (st_next.w_strb[0]) begin
						st_next.clk_on = st_next.w_data[`CLK_CTRL_ON_BIT];
					end
				end
				`OFF_OWN_STAT, `OFF_OUT_STAT, `OFF_PIN_LEVEL, `OFF_MD_STAT,
				`OFF_PU_STAT, `OFF_SEL_STAT, `OFF_WM_STAT: begin
					st_next.bresp = `RESP_OKAY;
				end
				default: begin
					st_next.bresp = `RESP_SLVERR;
				end
			endcase
		end
		// a line without a peripheral can never leave controller control
		st_next.ownership_status = (st_next.ownership_status | FIXED_OWN)
			& LINE_PRESENT;
		st_next.awready = !st_next.aw_held && !st_next.bvalid;
		st_next.wready = !st_next.w_held && !st_next.bvalid;

		// read channel: one outstanding read, data from the current state
		if (st_reg.rvalid && rready) begin
			st_next.rvalid = 1'b0;
		end
		if (arvalid && st_reg.arready) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = `RESP_OKAY;
			st_next.rdata = '0;
			case (araddr)
				`OFF_OWN_STAT: st_next.rdata = st_reg.ownership_status;
				`OFF_OUT_STAT: st_next.rdata = st_reg.output_status;
				`OFF_ODATA_STAT: st_next.rdata = st_reg.odata_status;
				`OFF_PIN_LEVEL: st_next.rdata = st_reg.pin_level;
				`OFF_MD_STAT: st_next.rdata = st_reg.md_status;
				`OFF_PU_STAT: st_next.rdata = st_reg.pu_status;
				`OFF_SEL_STAT: st_next.rdata = st_reg.ab_status;
				`OFF_WM_STAT: st_next.rdata = st_reg.wmask_status;
				`OFF_CLK_CTRL: st_next.rdata = {31'h0000_0000, st_reg.clk_on};
				`OFF_OWN_EN, `OFF_OWN_DIS, `OFF_OUT_EN, `OFF_OUT_DIS,
				`OFF_SET_OUT, `OFF_CLR_OUT, `OFF_MD_EN, `OFF_MD_DIS,
				`OFF_PU_DIS, `OFF_PU_EN, `OFF_SEL_A, `OFF_SEL_B,
				`OFF_WM_EN, `OFF_WM_DIS: st_next.rdata = '0;
				default: st_next.rresp = `RESP_SLVERR;
			endcase
		end
		st_next.arready = !st_next.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= RESET_STATE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign awready = st_reg.awready;
	assign wready = st_reg.wready;
	assign bvalid = st_reg.bvalid;
	assign bresp = st_reg.bresp;
	assign arready = st_reg.arready;
	assign rvalid = st_reg.rvalid;
	assign rdata = st_reg.rdata;
	assign rresp = st_reg.rresp;
	assign pin_out = st_reg.pad_out;
	assign pin_oe = st_reg.pad_oe;
	assign pin_pullup_en = st_reg.pull_on;
	assign periph_in = st_reg.periph_in;

	// checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_write_joined;
		wr_do;
	endsequence

	sequence s_write_answered;
		bvalid && !awready && !wready;
	endsequence

	a_write_answer: assert property (
		s_write_joined |=> s_write_answered)
		else $error("write not answered one cycle after it was joined");

	a_pullup_enable: assert property (
		wr_do && wr_addr == `OFF_PU_EN |=> (st_reg.pu_status & $past(act_bits)) == '0)
		else $error("pull-up enable write left a status bit set");

	a_reset_values: assert property (
		$rose(aresetn) |-> st_reg.pu_status == '0 && st_reg.ab_status == '0
			&& st_reg.wmask_status == '0 && st_reg.md_status == '0)
		else $error("status register not zero after reset");

	a_fixed_owner: assert property (
		(st_reg.ownership_status & FIXED_OWN) == FIXED_OWN)
		else $error("unmuxed line lost controller ownership");

	a_select_b: assert property (
		wr_do && wr_addr == `OFF_SEL_B |=> (st_reg.ab_status & $past(act_bits))
			== $past(act_bits))
		else $error("peripheral b select did not set selection bit");

	a_mask_write: assert property (
		wr_do && wr_addr == `OFF_ODATA_STAT |=>
			((st_reg.odata_status ^ $past(st_reg.odata_status))
			& ~$past(st_reg.wmask_status)) == '0)
		else $error("direct data write changed a masked line");

	a_open_drain: assert property (
		aresetn |=> (pin_oe & pin_out) == '0 || ($past(st_reg.md_status)
			& pin_oe & pin_out) == '0)
		else $error("multi-drive line driven high");

	a_periph_drive: assert property (
		aresetn |=> ((pin_oe ^ $past(periph_a_oe)) & $past(~st_reg.ownership_status
			& ~st_reg.ab_status & ~st_reg.md_status & LINE_PRESENT)) == '0)
		else $error("peripheral a does not control its pad enable");

	a_level_frozen: assert property (
		!st_reg.clk_on |=> $stable(st_reg.pin_level))
		else $error("pin level changed with controller clock stopped");

	a_absent_zero: assert property (
		rvalid |-> (rdata & ~LINE_PRESENT) == '0 || araddr == `OFF_CLK_CTRL
			|| $past(araddr) == `OFF_CLK_CTRL)
		else $error("absent line bit read as one");

	a_pullup_pad: assert property (
		aresetn |=> pin_pullup_en == (~$past(st_reg.pu_status) & LINE_PRESENT))
		else $error("pull-up pad enable does not follow status");

	// three quiet reset edges needed: the pipeline restarts at zero
	a_periph_input: assert property (
		$past(aresetn, 3) && $past(aresetn, 2) && $past(aresetn)
			|-> periph_in == ($past(pin_in, 3) & LINE_PRESENT))
		else $error("peripheral input does not follow the pin");

	a_owner_disable: assert property (
		wr_do && wr_addr == `OFF_OWN_DIS |=>
			(st_reg.ownership_status & $past(act_bits) & ~FIXED_OWN) == '0)
		else $error("ownership disable write left a status bit set");

	a_output_enable: assert property (
		wr_do && wr_addr == `OFF_OUT_EN |=>
			(st_reg.output_status & $past(act_bits)) == $past(act_bits))
		else $error("output enable write did not set direction bit");

	a_data_clear: assert property (
		wr_do && wr_addr == `OFF_CLR_OUT |=>
			(st_reg.odata_status & $past(act_bits)) == '0)
		else $error("clear output write left a data bit set");

	a_zero_bits: assert property (
		wr_do && wr_addr == `OFF_OWN_EN |=> ((st_reg.ownership_status
			^ $past(st_reg.ownership_status)) & ~$past(act_bits)) == '0)
		else $error("ownership enable write moved a line written as zero");
endmodule : parallel_io_controller
`default_nettype wire

// *** testbench/pad_periph_model.sv ***
// pads and two on-chip peripherals beside the io line controller
// assumes the controller's aclk and its registered pad outputs
`timescale 1ns/1ps
`default_nettype none
module pad_periph_model #(
	parameter gpio_ctrl_pkg::lines_type A_OUT = 32'hA5A5_A5A5,
	parameter gpio_ctrl_pkg::lines_type A_OE = 32'hFFFF_FFFF,
	parameter gpio_ctrl_pkg::lines_type B_OUT = 32'h5A5A_5A5A,
	parameter gpio_ctrl_pkg::lines_type B_OE = 32'h0000_FFFF
) (
	// clock
	input wire logic aclk,
	// pads
	input wire gpio_ctrl_pkg::lines_type pin_out,
	input wire gpio_ctrl_pkg::lines_type pin_oe,
	input wire gpio_ctrl_pkg::lines_type pin_pullup_en,
	output gpio_ctrl_pkg::lines_type pin_in,
	// peripheral drive requests
	output gpio_ctrl_pkg::lines_type a_out,
	output gpio_ctrl_pkg::lines_type a_oe,
	output gpio_ctrl_pkg::lines_type b_out,
	output gpio_ctrl_pkg::lines_type b_oe
);
	import gpio_ctrl_pkg::*;
	lines_type last_lvl = 32'h0000_0000;
	always @(posedge aclk) begin
		last_lvl <= pin_in;
	end
	// a floating pad without pull-up never holds its old level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pullup_en | ~last_lvl));
	// fixed patterns keep expected pad levels easy to derive
	assign a_out = A_OUT;
	assign a_oe = A_OE;
	assign b_out = B_OUT;
	assign b_oe = B_OE;
endmodule : pad_periph_model
`default_nettype wire

// *** testbench/parallel_io_controller_tb.sv ***
// register and pad checks for the io line controller
// assumes the pad model file and the controller's constants header
`timescale 1ns/1ps
`default_nettype none
`include "gpio_ctrl_defs.svh"
module parallel_io_controller_tb;
	import gpio_ctrl_pkg::*;
	localparam lines_type LP = 32'h7FFF_FFFF;
	localparam lines_type AO = 32'hA5A5_A5A5;
	localparam lines_type AE = 32'hFFFF_FFFF;
	localparam lines_type BO = 32'h5A5A_5A5A;
	localparam lines_type BE = 32'h0000_FFFF;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdat_q, exp_oe, exp_out, lvl;
	logic [3:0] wstrb;
	logic [1:0] resp_q;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire lines_type pin_in, pin_out, pin_oe, pin_pu, p_in;
	wire lines_type a_out, a_oe, b_out, b_oe;
	int error_cnt, compares;
	logic [7:0] ra [7] = '{`OFF_OWN_STAT, `OFF_SEL_STAT, `OFF_OUT_STAT,
		`OFF_PU_STAT, `OFF_MD_STAT, `OFF_WM_STAT, `OFF_CLK_CTRL};
	logic [31:0] rv [7] = '{32'h7FFF_FF0F, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
	logic [7:0] wo [5] = '{`OFF_OWN_EN, `OFF_SET_OUT, `OFF_WM_DIS,
		`OFF_MD_EN, `OFF_SEL_B};

	// line 31 absent, line 0 unmuxed, lines 4..7 reset to peripheral
	parallel_io_controller #(
		.LINE_PRESENT(LP),
		.MUX_PRESENT(32'hFFFF_FFFE),
		.OWNERSHIP_RESET(32'hFFFF_FF0F)
	) dut (
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup_en(pin_pu),
		.periph_a_out(a_out), .periph_a_oe(a_oe),
		.periph_b_out(b_out), .periph_b_oe(b_oe),
		.periph_in(p_in)
	);
	pad_periph_model #(
		.A_OUT(AO), .A_OE(AE), .B_OUT(BO), .B_OE(BE)
	) model (
		.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup_en(pin_pu), .pin_in(pin_in),
		.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe)
	);

	always #50 aclk = ~aclk;

	function automatic logic [31:0] pick(input logic [31:0] s, x, y);
		return (s & x) | (~s & y);
	endfunction : pick

	task report_and_stop();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task rspchk(input logic [1:0] got, input logic [1:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : rspchk

	// address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic done;
		n = 0;
		done = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done && n < 20) begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				done = 1;
				bready <= 1'b0;
				resp_q = bresp;
			end
		end
		if (!done) begin
			error_cnt++;
			report_and_stop();
		end
	endtask : wr

	task rd(input logic [7:0] a);
		int n;
		logic done;
		n = 0;
		done = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done && n < 20) begin
			@(posedge aclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				done = 1;
				rready <= 1'b0;
				rdat_q = rdata;
				resp_q = rresp;
			end
		end
		if (!done) begin
			error_cnt++;
			report_and_stop();
		end
	endtask : rd

	task rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rdat_q, exp);
	endtask : rchk

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		error_cnt = 0;
		compares = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			rchk(ra[i], rv[i]);
		chk(pin_pu, LP);
		rchk(`OFF_PIN_LEVEL, 32'h0000_0000);
		rspchk(resp_q, 2'h0);
		for (int i = 0; i < 5; i++)
			rchk(wo[i], 32'h0000_0000);
		wr(8'hFC, 32'hFFFF_FFFF);
		rspchk(resp_q, 2'h2);
		rchk(8'hFC, 32'h0000_0000);
		rspchk(resp_q, 2'h2);
		wr(`OFF_PU_DIS, 32'hFFFF_FFFF);
		rspchk(resp_q, 2'h0);
		rchk(`OFF_PU_STAT, 32'h7FFF_FFFF);
		wr(`OFF_PU_EN, 32'hFFFF_FF0F);
		rchk(`OFF_PU_STAT, 32'h0000_00F0);
		chk(pin_pu, 32'h7FFF_FF0F);
		wr(`OFF_PU_EN, 32'hFFFF_FFFF);
		wr(`OFF_OWN_DIS, 32'hFFFF_FFFF);
		rchk(`OFF_OWN_STAT, 32'h0000_0001);
		wr(`OFF_OWN_EN, 32'h0000_00F0);
		rchk(`OFF_OWN_STAT, 32'h0000_00F1);
		// line 4 is controller-owned: selection must still move
		wr(`OFF_SEL_B, 32'h0000_FF10);
		wr(`OFF_SEL_A, 32'h0000_0F00);
		rchk(`OFF_SEL_STAT, 32'h0000_F010);
		wr(`OFF_OUT_EN, 32'h0000_03F1);
		wr(`OFF_OUT_DIS, 32'h0000_0200);
		rchk(`OFF_OUT_STAT, 32'h0000_01F1);
		wr(`OFF_SET_OUT, 32'h0000_0131);
		wr(`OFF_CLR_OUT, 32'h0000_0120);
		rchk(`OFF_ODATA_STAT, 32'h0000_0011);
		wr(`OFF_ODATA_STAT, 32'hFFFF_FFFF);
		rchk(`OFF_ODATA_STAT, 32'h0000_0011);
		wr(`OFF_WM_EN, 32'h0000_00F0);
		wr(`OFF_ODATA_STAT, 32'h0000_00A0);
		rchk(`OFF_ODATA_STAT, 32'h0000_00A1);
		wr(`OFF_MD_EN, 32'h0000_00FF);
		wr(`OFF_MD_DIS, 32'h0000_000F);
		// only lane 0 strobed, its bits zero: upper lanes must not act
		wstrb <= 4'h1;
		wr(`OFF_MD_EN, 32'hFFFF_FF00);
		wstrb <= 4'hF;
		rchk(`OFF_MD_STAT, 32'h0000_00F0);
		// level reads only after the controller clock is on
		wr(`OFF_CLK_CTRL, 32'h0000_0001);
		repeat (6) @(posedge aclk);
		exp_oe = pick(32'h0000_00F1, 32'h0000_01F1, pick(32'h0000_F010, BE, AE));
		exp_out = pick(32'h0000_00F1, 32'h0000_00A1, pick(32'h0000_F010, BO, AO));
		exp_oe = exp_oe & ~(32'h0000_00F0 & exp_out) & LP;
		exp_out = exp_out & ~32'h0000_00F0;
		lvl = ((exp_oe & exp_out) | ~exp_oe) & LP;
		chk(pin_oe & LP, exp_oe);
		chk(pin_out & exp_oe, exp_out & exp_oe);
		chk(p_in & LP, lvl);
		rchk(`OFF_PIN_LEVEL, lvl);
		report_and_stop();
	end
endmodule : parallel_io_controller_tb
`default_nettype wire
